// File: power_mode_controller.sv
/*
 * Operating mode controller: five modes, PLL enable and bypass, core and system clock
 * enables, wake-up handling, DMA gating and a regulator-safe output, programmed over
 * AXI4-Lite. Assumes core status inputs and wake events are synchronous to mclk.
 */
`timescale 1ns/1ps
`include "power_mode_defines.svh"

// How it works
// - Full on: PLL enabled and not bypassed, core and system clocks run.
// - Active: PLL enabled but bypassed, clocks come straight from the input clock.
// - Relaxed: PLL bypassed and disabled, clocks come from the input clock.
// - A new divider ratio is taken while bypassed, applied when lock wait expires.
// - System DMA into level-one memory is allowed in active and relaxed modes.
// - Sleep: core clock stopped, system clock keeps running.
// - System DMA into level-one memory is refused in sleep.
// - Any interrupt wakes sleep; bypass bit picks full on or active.
// - Deep sleep: core and system clocks both stopped.
// - Deep sleep ends only on reset request or real-time-clock interrupt.
// - Reset request in deep sleep: bypass pin picks full on or active.
// - Real-time-clock interrupt in deep sleep always gives full on.
// - Regulator-safe output is high while in deep sleep.
// - Core-quiesced rises only after pipeline drained and sync acknowledged.
// - System clock is core clock divided by 2, 2.5, 3 or 4.
module power_mode_controller
   import power_mode_pkg::*;
#(
   parameter int LOCK_WIDTH = 16
) (
   input wire logic mclk,
   input wire logic rst,
   input wire axil_req_t axi_req,
   output axil_rsp_t axi_rsp,
   input wire logic idle_request,
   input wire logic pipeline_drained,
   input wire logic sync_ack,
   input wire logic any_interrupt,
   input wire logic rtc_interrupt,
   input wire logic reset_request,
   input wire logic bypass_pin,
   input wire logic dma_request,
   output power_ctl_t power_ctl,
   output mode_t mode
);

   ////////////////////////////////////////////////////////////////////////////////
   // Parameter check.

   // The lock wait field is fixed at sixteen bits in the register map.
   if (LOCK_WIDTH != 16) begin : lock_width_check
      $error("LOCK_WIDTH must be 16.");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Helper functions.

   // Clock and PLL controls that each mode fixes.
   function automatic power_ctl_t mode_controls(input mode_t m);
      power_ctl_t c;
      c = '0;
      case (m)
         MODE_FULL_ON: begin
            c.pll_enable = 1'b1;
            c.pll_bypass = 1'b0;
            c.core_clock_en = 1'b1;
         end
         MODE_ACTIVE: begin
            c.pll_enable = 1'b1;
            c.pll_bypass = 1'b1;
            c.core_clock_en = 1'b1;
         end
         MODE_RELAXED: begin
            c.pll_enable = 1'b0;
            c.pll_bypass = 1'b1;
            c.core_clock_en = 1'b1;
         end
         MODE_SLEEP: begin
            c.pll_bypass = 1'b1;
            c.core_clock_en = 1'b0;
         end
         default: begin
            c.pll_bypass = 1'b1;
            c.core_clock_en = 1'b0;
            c.regulator_safe = 1'b1;
         end
      endcase
      return c;
   endfunction : mode_controls

   // Divider period in half core cycles.
   function automatic logic [3:0] half_period(input logic [1:0] sel);
      logic [3:0] p;
      p = `HALF_DIV_2_0;
      case (sel)
         2'h0: p = `HALF_DIV_2_0;
         2'h1: p = `HALF_DIV_2_5;
         2'h2: p = `HALF_DIV_3_0;
         default: p = `HALF_DIV_4_0;
      endcase
      return p;
   endfunction : half_period

   // True for a code that names one of the five modes.
   function automatic logic mode_valid(input logic [2:0] code);
      return (code == MODE_FULL_ON) || (code == MODE_ACTIVE) || (code == MODE_RELAXED) ||
         (code == MODE_SLEEP) || (code == MODE_DEEP_SLEEP);
   endfunction : mode_valid

   // Byte-lane merge of write data into an old register value.
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   ////////////////////////////////////////////////////////////////////////////////
   // State.

   state_t s;
   state_t next_s;

   ////////////////////////////////////////////////////////////////////////////////
   // Next-state logic.

   // Fills the next state from the bus, the core status and the wake events.
   always_comb begin
      logic [31:0] ctl_word;
      logic [31:0] status_word;
      logic [31:0] lock_word;
      logic [31:0] wr_word;
      logic [4:0] acc_sum;
      logic [3:0] period;
      logic running;
      power_ctl_t mc;
      ctl_word = '0;
      status_word = '0;
      lock_word = '0;
      wr_word = '0;
      acc_sum = '0;
      period = '0;
      running = 1'b0;
      mc = '0;
      next_s = s;

      // Register images as software reads them.
      ctl_word[`FLD_TARGET_LSB +: 3] = s.target;
      ctl_word[`FLD_BYPASS] = s.bypass;
      ctl_word[`FLD_DIV_LSB +: 2] = s.div_pend ? s.pend_div : s.div_sel;
      status_word[2:0] = s.mode;
      status_word[`FLD_QUIESCED] = s.ctl.core_quiesced;
      status_word[`FLD_DIV_LSB +: 2] = s.div_sel;
      status_word[`FLD_LOCK_BUSY] = s.div_pend;
      status_word[`FLD_DMA_OPEN] = s.ctl.dma_grant;
      lock_word[15:0] = s.lock_load;

      // Write address and data are taken in either order; the response follows both.
      if (axi_req.awvalid && s.rsp.awready) begin
         next_s.aw_got = 1'b1;
         next_s.awaddr = axi_req.awaddr;
         next_s.rsp.awready = 1'b0;
      end
      if (axi_req.wvalid && s.rsp.wready) begin
         next_s.w_got = 1'b1;
         next_s.wdata = axi_req.wdata;
         next_s.wstrb = axi_req.wstrb;
         next_s.rsp.wready = 1'b0;
      end
      if (s.rsp.bvalid && axi_req.bready) begin
         next_s.rsp.bvalid = 1'b0;
         next_s.rsp.awready = 1'b1;
         next_s.rsp.wready = 1'b1;
      end

      // Lock wait countdown runs only while the PLL is bypassed.
      if (s.div_pend && s.ctl.pll_bypass) begin
         if (s.lock_cnt == '0) begin
            next_s.div_sel = s.pend_div;
            next_s.div_pend = 1'b0;
         end else begin
            next_s.lock_cnt = s.lock_cnt - 16'h0001;
         end
      end

      // Register write once both halves are held.
      if (s.aw_got && s.w_got && !s.rsp.bvalid) begin
         next_s.aw_got = 1'b0;
         next_s.w_got = 1'b0;
         next_s.rsp.bvalid = 1'b1;
         next_s.rsp.bresp = `RESP_OKAY;
         if (s.awaddr[7:2] == `OFS_PLL_CONTROL >> 2) begin
            wr_word = merge(ctl_word, s.wdata, s.wstrb);
            if (mode_valid(wr_word[`FLD_TARGET_LSB +: 3])) begin
               next_s.target = mode_t'(wr_word[`FLD_TARGET_LSB +: 3]);
            end
            next_s.bypass = wr_word[`FLD_BYPASS];
            if (wr_word[`FLD_DIV_LSB +: 2] != ctl_word[`FLD_DIV_LSB +: 2]) begin
               next_s.pend_div = wr_word[`FLD_DIV_LSB +: 2];
               next_s.div_pend = 1'b1;
               next_s.lock_cnt = s.lock_load;
            end
         end else if (s.awaddr[7:2] == `OFS_LOCK_WAIT >> 2) begin
            wr_word = merge(lock_word, s.wdata, s.wstrb);
            next_s.lock_load = wr_word[15:0];
         end else if (s.awaddr[7:2] == `OFS_MODE_STATUS >> 2) begin
            next_s.rsp.bresp = `RESP_OKAY;
         end else begin
            next_s.rsp.bresp = `RESP_SLVERR;
         end
      end

      // Read channel: one cycle from address to data.
      if (s.rsp.rvalid && axi_req.rready) begin
         next_s.rsp.rvalid = 1'b0;
         next_s.rsp.arready = 1'b1;
      end
      if (axi_req.arvalid && s.rsp.arready) begin
         next_s.rsp.arready = 1'b0;
         next_s.rsp.rvalid = 1'b1;
         next_s.rsp.rresp = `RESP_OKAY;
         if (axi_req.araddr[7:2] == `OFS_PLL_CONTROL >> 2) begin
            next_s.rsp.rdata = ctl_word;
         end else if (axi_req.araddr[7:2] == `OFS_MODE_STATUS >> 2) begin
            next_s.rsp.rdata = status_word;
         end else if (axi_req.araddr[7:2] == `OFS_LOCK_WAIT >> 2) begin
            next_s.rsp.rdata = lock_word;
         end else begin
            next_s.rsp.rdata = '0;
            next_s.rsp.rresp = `RESP_SLVERR;
         end
      end

      // Quiesce after idle, drained pipeline and sync acknowledge.
      running = (s.mode == MODE_FULL_ON) || (s.mode == MODE_ACTIVE) ||
         (s.mode == MODE_RELAXED);
      if (running && idle_request && pipeline_drained && sync_ack) begin
         next_s.ctl.core_quiesced = 1'b1;
      end

      // Mode sequencing.
      case (s.mode)
         MODE_SLEEP: begin
            if (any_interrupt) begin
               next_s.mode = s.bypass ? MODE_ACTIVE : MODE_FULL_ON;
               next_s.ctl.core_quiesced = 1'b0;
            end
         end
         MODE_DEEP_SLEEP: begin
            // Only these two events end deep sleep; the rest are ignored.
            if (rtc_interrupt) begin
               next_s.mode = MODE_FULL_ON;
               next_s.ctl.core_quiesced = 1'b0;
            end else if (reset_request) begin
               next_s.mode = bypass_pin ? MODE_ACTIVE : MODE_FULL_ON;
               next_s.ctl.core_quiesced = 1'b0;
            end
         end
         default: begin
            // A new mode waits until the core stands idle after the sync.
            if (s.ctl.core_quiesced) begin
               if (s.target != s.mode) begin
                  next_s.mode = s.target;
                  next_s.ctl.core_quiesced = (s.target == MODE_SLEEP) ||
                     (s.target == MODE_DEEP_SLEEP);
               end else if (any_interrupt) begin
                  next_s.ctl.core_quiesced = 1'b0;
               end
            end
         end
      endcase

      // Clock and PLL controls follow the next mode.
      mc = mode_controls(next_s.mode);
      next_s.ctl.pll_enable = mc.pll_enable;
      next_s.ctl.pll_bypass = mc.pll_bypass;
      next_s.ctl.core_clock_en = mc.core_clock_en;
      next_s.ctl.regulator_safe = mc.regulator_safe;

      // System clock enable: fractional divider in half cycles, silent from the first
      // cycle of deep sleep, so no stray pulse escapes on entry.
      period = half_period(s.div_sel);
      if (next_s.mode == MODE_DEEP_SLEEP) begin
         next_s.ctl.sys_clock_en = 1'b0;
         next_s.acc = '0;
      end else begin
         acc_sum = {1'b0, s.acc} + 5'h02;
         if (acc_sum >= {1'b0, period}) begin
            next_s.ctl.sys_clock_en = 1'b1;
            next_s.acc = 4'(acc_sum - {1'b0, period});
         end else begin
            next_s.ctl.sys_clock_en = 1'b0;
            next_s.acc = acc_sum[3:0];
         end
      end

      // DMA into level-one memory only while the core clock mode allows it.
      next_s.ctl.dma_grant = dma_request && ((next_s.mode == MODE_ACTIVE) ||
         (next_s.mode == MODE_RELAXED) || (next_s.mode == MODE_FULL_ON));
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register.

   // Registers the state; reset brings the device up in full on.
   always_ff @(posedge mclk) begin
      if (rst) begin
         s <= '0;
         s.mode <= MODE_FULL_ON;
         s.target <= MODE_FULL_ON;
         s.div_sel <= `RST_DIV_SEL;
         s.lock_load <= `RST_LOCK_WAIT;
         s.rsp.awready <= 1'b1;
         s.rsp.wready <= 1'b1;
         s.rsp.arready <= 1'b1;
         s.ctl.pll_enable <= 1'b1;
         s.ctl.core_clock_en <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs, straight from the state register.

   // Every output is a field of the registered state.
   assign axi_rsp = s.rsp;
   assign power_ctl = s.ctl;
   assign mode = s.mode;

endmodule : power_mode_controller

// File: power_mode_defines.svh
/*
 * Offsets, field positions, reset values and timing counts of the power mode controller.
 * Assumes it is included by its bare name wherever these macros are needed.
 */
`ifndef POWER_MODE_DEFINES_SVH
`define POWER_MODE_DEFINES_SVH

// Register byte offsets on the AXI4-Lite slave.
`define OFS_PLL_CONTROL 8'h00
`define OFS_MODE_STATUS 8'h04
`define OFS_LOCK_WAIT 8'h08

// Field positions of the PLL control register.
`define FLD_TARGET_LSB 0
`define FLD_BYPASS 3
`define FLD_DIV_LSB 4

// Field positions of the mode status register.
`define FLD_QUIESCED 3
`define FLD_LOCK_BUSY 6
`define FLD_DMA_OPEN 7

// Reset values.
`define RST_DIV_SEL 2'h0
`define RST_LOCK_WAIT 16'h0200

// Divider periods in half core cycles for the four divider selections.
`define HALF_DIV_2_0 4'h4
`define HALF_DIV_2_5 4'h5
`define HALF_DIV_3_0 4'h6
`define HALF_DIV_4_0 4'h8

// AXI responses.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: power_mode_pkg.sv
/*
 * Types of the power mode controller: modes, bus carriers and the state record.
 * Assumes nothing of its surroundings.
 */
package power_mode_pkg;

   // Operating modes, Gray coded along full on, active, relaxed, sleep, deep sleep.
   typedef enum logic [2:0] {
      MODE_FULL_ON = 3'h0,
      MODE_ACTIVE = 3'h1,
      MODE_RELAXED = 3'h3,
      MODE_SLEEP = 3'h2,
      MODE_DEEP_SLEEP = 3'h6
   } mode_t;

   // AXI4-Lite signals driven by the master.
   typedef struct packed {
      logic awvalid;
      logic [7:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [7:0] araddr;
      logic rready;
   } axil_req_t;

   // AXI4-Lite signals driven by the slave.
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } axil_rsp_t;

   // Clock and power controls sent to the clock tree, PLL and regulator.
   typedef struct packed {
      logic pll_enable;
      logic pll_bypass;
      logic core_clock_en;
      logic sys_clock_en;
      logic regulator_safe;
      logic core_quiesced;
      logic dma_grant;
   } power_ctl_t;

   // Whole state of the controller.
   typedef struct packed {
      mode_t mode;
      mode_t target;
      logic bypass;
      logic [1:0] div_sel;
      logic [1:0] pend_div;
      logic div_pend;
      logic [15:0] lock_cnt;
      logic [15:0] lock_load;
      logic [3:0] acc;
      logic aw_got;
      logic [7:0] awaddr;
      logic w_got;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      axil_rsp_t rsp;
      power_ctl_t ctl;
   } state_t;

endpackage : power_mode_pkg

// File: power_mode_checker.sv
/*
 * Assertions on the ports of the power mode controller.
 * Assumes it is bound to power_mode_controller and rst is synchronous.
 */
`timescale 1ns/1ps
module power_mode_checker
   import power_mode_pkg::*;
#(
   parameter int LOCK_WIDTH = 16
) (
   input wire logic mclk,
   input wire logic rst,
   input wire axil_req_t axi_req,
   input wire axil_rsp_t axi_rsp,
   input wire logic idle_request,
   input wire logic pipeline_drained,
   input wire logic sync_ack,
   input wire logic any_interrupt,
   input wire logic rtc_interrupt,
   input wire logic reset_request,
   input wire logic bypass_pin,
   input wire logic dma_request,
   input wire power_ctl_t power_ctl,
   input wire mode_t mode
);
   default clocking @(posedge mclk);
   endclocking
   default disable iff (rst);

   // Wake events out of the two stopped modes.
   sequence sleep_wake_s;
      mode == MODE_SLEEP && any_interrupt;
   endsequence
   sequence deep_rtc_s;
      mode == MODE_DEEP_SLEEP && rtc_interrupt;
   endsequence
   sequence deep_reset_s;
      mode == MODE_DEEP_SLEEP && reset_request && !rtc_interrupt;
   endsequence

   ////////////////////////////////////////////////////////////////////////////////
   full_on_ctl_a: assert property (
      mode == MODE_FULL_ON |-> power_ctl.pll_enable && !power_ctl.pll_bypass
      && power_ctl.core_clock_en) else $error("full on controls wrong");
   active_ctl_a: assert property (
      mode == MODE_ACTIVE |-> power_ctl.pll_enable && power_ctl.pll_bypass
      && power_ctl.core_clock_en) else $error("active controls wrong");
   relaxed_ctl_a: assert property (
      mode == MODE_RELAXED |-> !power_ctl.pll_enable && power_ctl.pll_bypass
      && power_ctl.core_clock_en) else $error("relaxed controls wrong");
   deep_ctl_a: assert property (
      mode == MODE_DEEP_SLEEP |-> !power_ctl.core_clock_en && !power_ctl.sys_clock_en)
      else $error("clock running in deep sleep");
   regulator_safe_a: assert property (
      power_ctl.regulator_safe == (mode == MODE_DEEP_SLEEP)) else $error("regulator flag wrong");
   deep_stay_a: assert property (
      mode == MODE_DEEP_SLEEP && !rtc_interrupt && !reset_request |=> mode == MODE_DEEP_SLEEP)
      else $error("deep sleep left without cause");
   rtc_wake_a: assert property (
      deep_rtc_s |=> mode == MODE_FULL_ON) else $error("clock wake mode wrong");
   reset_wake_a: assert property (
      deep_reset_s |=> mode == ($past(bypass_pin) ? MODE_ACTIVE : MODE_FULL_ON))
      else $error("reset wake mode wrong");
   sleep_wake_a: assert property (
      sleep_wake_s |=> mode inside {MODE_FULL_ON, MODE_ACTIVE} && !power_ctl.core_quiesced)
      else $error("sleep wake wrong");
   quiesce_cause_a: assert property (
      $rose(power_ctl.core_quiesced) |-> $past(idle_request && pipeline_drained && sync_ack))
      else $error("quiesced without sync");
   mode_change_a: assert property (
      !$past(rst) && mode != $past(mode)
      && $past(mode) inside {MODE_FULL_ON, MODE_ACTIVE, MODE_RELAXED}
      |-> $past(power_ctl.core_quiesced)) else $error("mode changed while running");
   dma_gate_a: assert property (
      !$past(rst) |-> power_ctl.dma_grant == ($past(dma_request)
      && mode != MODE_SLEEP && mode != MODE_DEEP_SLEEP)) else $error("dma grant wrong");
endmodule : power_mode_checker

bind power_mode_controller power_mode_checker #(.LOCK_WIDTH(LOCK_WIDTH)) checker_i (
   .mclk(mclk), .rst(rst), .axi_req(axi_req), .axi_rsp(axi_rsp),
   .idle_request(idle_request), .pipeline_drained(pipeline_drained), .sync_ack(sync_ack),
   .any_interrupt(any_interrupt), .rtc_interrupt(rtc_interrupt),
   .reset_request(reset_request), .bypass_pin(bypass_pin), .dma_request(dma_request),
   .power_ctl(power_ctl), .mode(mode)
);

// File: core_model.sv
/*
 * Model of the core software and pipeline that bring the controller to idle.
 * Assumes go is held by the bench until the new mode is seen.
 */
`timescale 1ns/1ps
module core_model (
   input wire logic mclk,
   input wire logic go,
   input wire logic [3:0] lag,
   input wire logic core_quiesced,
   output logic idle_request = 1'b0,
   output logic pipeline_drained = 1'b0,
   output logic sync_ack = 1'b0
);
   ////////////////////////////////////////////////////////////////////////////////
   // Idle first, the pipeline drains after lag cycles, then the sync is acknowledged.
   always @(posedge mclk) begin
      if (go) begin
         idle_request <= 1'b1;
         repeat (lag) @(posedge mclk);
         pipeline_drained <= 1'b1;
         @(posedge mclk);
         sync_ack <= 1'b1;
         while (!core_quiesced) @(posedge mclk);
         idle_request <= 1'b0;
         pipeline_drained <= 1'b0;
         sync_ack <= 1'b0;
         while (go) @(posedge mclk);
      end
   end
endmodule : core_model

// File: tb_top.sv
/*
 * Self-checking bench: registers, mode walk, wake events, divider and DMA gating.
 * Assumes the core model and the bound checker are compiled with it.
 */
`timescale 1ns/1ps
`include "power_mode_defines.svh"
module tb_top
   import power_mode_pkg::*;
;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   axil_req_t req = '0;
   axil_rsp_t rsp;
   logic [2:0] wake = 3'h0;
   logic byp_pin = 1'b0;
   logic dma_req = 1'b0;
   logic go = 1'b0;
   logic [3:0] lag = 4'h0;
   logic idle_r;
   logic drained;
   logic ack;
   power_ctl_t ctl;
   mode_t mode;
   logic [31:0] rd;
   integer seed = 32'hCCE1;
   int n_errors = 0;
   int total_checks = 0;
   int cycles = 0;
   mode_t walk [8] = '{MODE_ACTIVE, MODE_RELAXED, MODE_FULL_ON, MODE_SLEEP,
      MODE_RELAXED, MODE_DEEP_SLEEP, MODE_SLEEP, MODE_DEEP_SLEEP};

   power_mode_controller #(.LOCK_WIDTH(16)) DUT (
      .mclk(mclk), .rst(rst), .axi_req(req), .axi_rsp(rsp), .idle_request(idle_r),
      .pipeline_drained(drained), .sync_ack(ack), .any_interrupt(wake[2]),
      .rtc_interrupt(wake[1]), .reset_request(wake[0]), .bypass_pin(byp_pin),
      .dma_request(dma_req), .power_ctl(ctl), .mode(mode));
   core_model partner (.mclk(mclk), .go(go), .lag(lag), .core_quiesced(ctl.core_quiesced),
      .idle_request(idle_r), .pipeline_drained(drained), .sync_ack(ack));

   // Clock of 10 ns period.
   always #5 mclk = ~mclk;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task conclude;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : conclude

   // Write both channels at once; each is dropped as soon as it is taken.
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge mclk);
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.wvalid <= 1'b1;
      req.wdata <= d;
      req.wstrb <= 4'hF;
      req.bready <= 1'b1;
      do begin
         @(posedge mclk);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
      end while (!rsp.bvalid);
      req.bready <= 1'b0;
      check(32'(rsp.bresp), 32'(er));
   endtask : axw

   task automatic axr(input logic [7:0] a, input logic [1:0] er);
      @(posedge mclk);
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b1;
      do begin
         @(posedge mclk);
         if (rsp.arready) req.arvalid <= 1'b0;
      end while (!rsp.rvalid);
      rd = rsp.rdata;
      req.rready <= 1'b0;
      check(32'(rsp.rresp), 32'(er));
   endtask : axr

   // One-cycle wake event: bit 2 any interrupt, bit 1 clock alarm, bit 0 reset.
   task automatic kick(input logic [2:0] v);
      @(posedge mclk);
      wake <= v;
      @(posedge mclk);
      wake <= 3'h0;
      @(posedge mclk);
   endtask : kick

   task automatic pulses(output int n);
      n = 0;
      repeat (60) begin
         @(posedge mclk);
         n += int'(ctl.sys_clock_en);
      end
   endtask : pulses

   // System clock pulses in 60 cycles at ratios 2, 2.5, 3 and 4.
   function automatic int exp_pulses(input logic [1:0] d);
      case (d)
         2'h0: return 30;
         2'h1: return 24;
         2'h2: return 20;
         default: return 15;
      endcase
   endfunction : exp_pulses

   // Expected {pll enable, core clock, regulator flag} of each mode.
   function automatic logic [2:0] exp_ctl(input mode_t m);
      case (m)
         MODE_FULL_ON, MODE_ACTIVE: return 3'h6;
         MODE_RELAXED: return 3'h2;
         MODE_SLEEP: return 3'h0;
         default: return 3'h1;
      endcase
   endfunction : exp_ctl

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      logic [31:0] r;
      int n;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      axr(`OFS_LOCK_WAIT, `RESP_OKAY);
      check(rd, 32'(`RST_LOCK_WAIT));
      axr(8'h0C, `RESP_SLVERR);
      check(rd, 32'h0);
      axw(8'h0C, 32'h5, `RESP_SLVERR);
      axw(`OFS_LOCK_WAIT, 32'h4, `RESP_OKAY);
      axr(`OFS_LOCK_WAIT, `RESP_OKAY);
      check(rd, 32'h4);
      $display("test registers done");
      axw(`OFS_PLL_CONTROL, 32'h37, `RESP_OKAY);
      axr(`OFS_PLL_CONTROL, `RESP_OKAY);
      check(rd, 32'h30);
      axw(`OFS_MODE_STATUS, 32'hFF, `RESP_OKAY);
      repeat (20) @(posedge mclk);
      axr(`OFS_MODE_STATUS, `RESP_OKAY);
      check(rd & 32'h7F, 32'h40);
      $display("test divider hold done");
      for (int i = 0; i < 8; i++) begin
         r = $random(seed);
         dma_req <= 1'b0;
         lag <= r[9:6];
         byp_pin <= r[1];
         axw(`OFS_PLL_CONTROL, {26'h0, r[5:3], walk[i]}, `RESP_OKAY);
         // The new target must wait until the core has quiesced.
         repeat (4) @(posedge mclk);
         check(32'(mode == walk[i]), 32'h0);
         go <= 1'b1;
         while (mode !== walk[i]) @(posedge mclk);
         go <= 1'b0;
         check(32'({ctl.pll_enable, ctl.core_clock_en, ctl.regulator_safe}),
            32'(exp_ctl(walk[i])));
         dma_req <= r[2];
         repeat (2) @(posedge mclk);
         check(32'(ctl.dma_grant), 32'(r[2] && walk[i] != MODE_SLEEP
            && walk[i] != MODE_DEEP_SLEEP));
         if (walk[i] == MODE_SLEEP) begin
            pulses(n);
            check(32'(n != 0), 32'h1);
            kick(3'h4);
            check(32'(mode), 32'(r[3] ? MODE_ACTIVE : MODE_FULL_ON));
         end else if (walk[i] == MODE_DEEP_SLEEP) begin
            pulses(n);
            check(32'(n), 32'h0);
            kick(3'h4);
            check(32'(mode), 32'(MODE_DEEP_SLEEP));
            kick(i == 5 ? 3'h2 : 3'h1);
            check(32'(mode), 32'(i == 5 || !r[1] ? MODE_FULL_ON : MODE_ACTIVE));
         end else begin
            if (walk[i] != MODE_FULL_ON) begin
               repeat (10) @(posedge mclk);
               pulses(n);
               check(32'(n), 32'(exp_pulses(r[5:4])));
            end
            // Idle again with the target already reached, then clear it by an interrupt.
            go <= 1'b1;
            while (!ctl.core_quiesced) @(posedge mclk);
            go <= 1'b0;
            check(32'(mode), 32'(walk[i]));
            kick(3'h4);
            check(32'(ctl.core_quiesced), 32'h0);
         end
         $display("test mode step %0d done", i);
      end
      conclude();
   end

   // Watchdog against a hang.
   always @(posedge mclk) begin
      cycles++;
      if (cycles > 20000) begin
         n_errors++;
         conclude();
      end
   end
endmodule : tb_top
